// ---- design/dca_abort_top.sv ----
`timescale 1ns/1ns
module dca_abort_top #(
   parameter int unsigned SER_DIV         = dca_pkg::DCA_SER_DIV,
   parameter int unsigned ACK_TICKS       = dca_pkg::DCA_ACK_TICKS,
   parameter int unsigned SYNC_RESP_TICKS = dca_pkg::DCA_SYNC_RESP_TICKS
) (
   // Clock and reset.
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // Debug pin, open drain, driven low only.
   input  wire logic debug_pin_i,
   output logic      debug_pin_o,
   output logic      debug_pin_oe_o,
   // Command engine status.
   input  wire logic cmd_pending_i,
   input  wire logic cmd_run_to_bp_i,
   input  wire logic cmd_done_i,
   // Events to the command engine.
   output logic      cmd_abort_o,
   output logic      ack_cancel_o,
   output logic      sync_req_o,
   output logic      cmd_bit_fall_o,
   output logic      cmd_start_o,
   output logic      ser_tick_o
);
   import dca_pkg::*;

   localparam int unsigned DIV_W = (SER_DIV > 1) ? $clog2(SER_DIV) : 1;
   // Cycles from a pin change to the filtered level: three sync stages plus the level register.
   localparam int unsigned MASK_HOLD = 4;

   dca_low_if #(.CNT_W(DCA_CNT_W)) lm ();

   dca_state_type        state_reg;
   dca_state_type        state_next;
   logic [DIV_W-1:0]     div_reg;
   logic [DIV_W-1:0]     div_next;
   logic                 tick_reg;
   logic                 tick_next;
   logic [DCA_DUR_W-1:0] dur_reg;
   logic [DCA_DUR_W-1:0] dur_next;
   logic                 pend_reg;
   logic                 pend_next;
   logic                 ack_off_reg;
   logic                 ack_off_next;
   logic                 drive_reg;
   logic                 drive_next;
   logic                 abort_reg;
   logic                 abort_next;
   logic                 ack_cancel_reg;
   logic                 ack_cancel_next;
   logic                 sync_req_reg;
   logic                 sync_req_next;
   logic                 bit_fall_reg;
   logic                 bit_fall_next;
   logic                 start_reg;
   logic                 start_next;
   logic [MASK_HOLD-1:0] drv_hist_reg;
   logic [MASK_HOLD-1:0] drv_hist_next;

   // Serial clock divider; every slower activity runs on this one-cycle enable.
   always_comb begin
      tick_next = 1'b0;
      div_next  = div_reg + 1'b1;
      if (div_reg == DIV_W'(SER_DIV - 1)) begin
         div_next  = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   // History of our own drive; the synchroniser shows our edges four cycles late,
   // so the mask has to outlive the drive or a short acknowledge looks like a host edge.
   always_comb begin
      drv_hist_next = {drv_hist_reg[MASK_HOLD-2:0], drive_reg};
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         drv_hist_reg <= '0;
      end else begin
         drv_hist_reg <= drv_hist_next;
      end
   end

   // Low-time measurement; masking our own drive keeps our pulses from raising fall and rise events.
   assign lm.tick = tick_reg;
   assign lm.mask = drive_reg | (|drv_hist_reg);

   dca_low_meter #(
      .CNT_W      (DCA_CNT_W),
      .LONG_TICKS (DCA_SYNC_MIN_TICKS)
   ) u_meter (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .debug_pin_i (debug_pin_i),
      .lm          (lm)
   );

   // Abort state machine: watches host low pulses around a pending command.
   always_comb begin
      state_next      = state_reg;
      dur_next        = dur_reg;
      pend_next       = pend_reg;
      ack_off_next    = ack_off_reg;
      abort_next      = 1'b0;
      ack_cancel_next = 1'b0;
      sync_req_next   = 1'b0;
      bit_fall_next   = 1'b0;
      start_next      = 1'b0;
      unique case (state_reg)
         DCA_ST_IDLE: begin
            ack_off_next = 1'b0;
            if (lm.fall) begin
               bit_fall_next = 1'b1;
               pend_next     = 1'b0;
               state_next    = DCA_ST_MEAS; // R10
            end else if (cmd_pending_i) begin
               state_next = DCA_ST_PEND;
            end
         end
         DCA_ST_PEND: begin
            if (lm.fall) begin
               // A host edge kills the acknowledge at once, whatever the pulse turns out to be.
               ack_cancel_next = ~ack_off_reg; // R4
               ack_off_next    = 1'b1;
               pend_next       = 1'b1;
               state_next      = DCA_ST_MEAS;
            end else if (cmd_done_i) begin
               dur_next   = '0;
               state_next = ack_off_reg ? DCA_ST_IDLE : DCA_ST_ACK; // R1
            end else if (~cmd_pending_i) begin
               state_next = DCA_ST_IDLE;
            end
         end
         DCA_ST_ACK: begin
            if (tick_reg) begin
               dur_next = dur_reg + 1'b1;
               if (dur_reg == DCA_DUR_W'(ACK_TICKS - 1)) begin
                  state_next = DCA_ST_IDLE;
               end
            end
         end
         DCA_ST_MEAS: begin
            if (lm.rise) begin
               if (lm.long_low) begin
                  // Timing-reference request: answer it, and drop the command unless it is a run.
                  sync_req_next = 1'b1;
                  abort_next    = pend_reg & ~cmd_run_to_bp_i; // R9
                  dur_next      = '0;
                  state_next    = DCA_ST_SYNC;
               end else if (pend_reg) begin
                  // Short abort: no timing response; a run to breakpoint keeps running.
                  abort_next = ~cmd_run_to_bp_i; // R3
                  state_next = cmd_run_to_bp_i ? DCA_ST_PEND : DCA_ST_RESYNC; // R1
               end else begin
                  state_next = DCA_ST_IDLE; // R2
               end
            end
         end
         DCA_ST_SYNC: begin
            if (tick_reg) begin
               dur_next = dur_reg + 1'b1;
               if (dur_reg == DCA_DUR_W'(SYNC_RESP_TICKS - 1)) begin
                  state_next = (pend_reg && cmd_run_to_bp_i) ? DCA_ST_PEND : DCA_ST_IDLE; // R1
               end
            end
         end
         DCA_ST_RESYNC: begin
            // The host relies on a short abort being at least four ticks long to be seen here.
            if (lm.fall) begin
               start_next = 1'b1; // R7
               pend_next  = 1'b0;
               state_next = DCA_ST_MEAS;
            end
         end
      endcase
      drive_next = (state_next == DCA_ST_ACK) || (state_next == DCA_ST_SYNC);
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg      <= DCA_ST_IDLE;
         dur_reg        <= '0;
         pend_reg       <= 1'b0;
         ack_off_reg    <= 1'b0;
         drive_reg      <= 1'b0;
         abort_reg      <= 1'b0;
         ack_cancel_reg <= 1'b0;
         sync_req_reg   <= 1'b0;
         bit_fall_reg   <= 1'b0;
         start_reg      <= 1'b0;
      end else begin
         state_reg      <= state_next;
         dur_reg        <= dur_next;
         pend_reg       <= pend_next;
         ack_off_reg    <= ack_off_next;
         drive_reg      <= drive_next;
         abort_reg      <= abort_next;
         ack_cancel_reg <= ack_cancel_next;
         sync_req_reg   <= sync_req_next;
         bit_fall_reg   <= bit_fall_next;
         start_reg      <= start_next;
      end
   end

   // The pin is only ever pulled low; the host or a pull-up brings it high.
   assign debug_pin_o    = 1'b0;
   assign debug_pin_oe_o = drive_reg;
   assign cmd_abort_o    = abort_reg;
   assign ack_cancel_o   = ack_cancel_reg;
   assign sync_req_o     = sync_req_reg;
   assign cmd_bit_fall_o = bit_fall_reg;
   assign cmd_start_o    = start_reg;
   assign ser_tick_o     = tick_reg;

endmodule : dca_abort_top

// ---- include/dca_pkg.sv ----
// Function
// R1: A pending run_to_breakpoint_cmd is never cancelled; a timing-reference request cancels only its acknowledge.
// R2: A host low pulse shorter than 128 serial clock ticks during a pending command is not a timing-reference request.
// R3: Such a short pulse skips the timing-reference response and cancels the pending command and its acknowledge.
// R4: The acknowledge is cancelled at the moment the device detects the falling edge on debug_pin.
// R5: The host holds a short abort pulse low for at least 4 target clock cycles so the falling edge is caught.
// R6: The host avoids the short abort pulse on read commands, since it may collide with the acknowledge.
// R7: After an abort, the first falling edge after the abort pulse starts the first bit of a fresh command.
// R8: The host may size a cancelling timing-reference request only slightly above 128 serial clock ticks.
// R9: After a timing-reference request cancels a byte-read, the host may start a new command and it is accepted.
// R10: The device counts each host low level in serial clock ticks and uses the count to classify the pulse.
package dca_pkg;

   // Low pulse classification thresholds, in serial clock ticks.
   localparam int unsigned DCA_SYNC_MIN_TICKS  = 128;
   localparam int unsigned DCA_ABORT_MIN_TICKS = 4;
   localparam int unsigned DCA_CNT_W           = 8;

   // System clock cycles per serial clock tick.
   localparam int unsigned DCA_SER_DIV         = 4;

   // Lengths of the pulses the device drives itself, in serial clock ticks.
   localparam int unsigned DCA_ACK_TICKS       = 16;
   localparam int unsigned DCA_SYNC_RESP_TICKS = 128;
   localparam int unsigned DCA_DUR_W           = 8;

   // Reset values.
   localparam logic        DCA_PIN_IDLE        = 1'b1;

   // Abort handling states.
   typedef enum logic [2:0] {
      DCA_ST_IDLE,
      DCA_ST_PEND,
      DCA_ST_ACK,
      DCA_ST_MEAS,
      DCA_ST_SYNC,
      DCA_ST_RESYNC
   } dca_state_type;

endpackage : dca_pkg

// ---- include/dca_low_if.sv ----
`timescale 1ns/1ns
interface dca_low_if #(
   parameter int unsigned CNT_W = dca_pkg::DCA_CNT_W
);
   logic             tick;
   logic             mask;
   logic             fall;
   logic             rise;
   logic             long_low;
   logic [CNT_W-1:0] low_cnt;

   modport meter (input tick, input mask, output fall, output rise, output long_low, output low_cnt);
   modport user  (output tick, output mask, input fall, input rise, input long_low, input low_cnt);
endinterface : dca_low_if

// ---- design/dca_low_meter.sv ----
`timescale 1ns/1ns
module dca_low_meter #(
   parameter int unsigned CNT_W      = dca_pkg::DCA_CNT_W,
   parameter int unsigned LONG_TICKS = dca_pkg::DCA_SYNC_MIN_TICKS
) (
   // Clock and reset.
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // Raw pin level.
   input  wire logic debug_pin_i,
   // Measurement results.
   dca_low_if.meter  lm
);
   import dca_pkg::*;

   logic [2:0]       sync_reg;
   logic [2:0]       sync_next;
   logic             level_reg;
   logic             level_next;
   logic             fall_reg;
   logic             fall_next;
   logic             rise_reg;
   logic             rise_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   // The level changes only once the second and third stages agree, which filters one-cycle glitches.
   always_comb begin
      sync_next  = {sync_reg[1:0], debug_pin_i};
      level_next = level_reg;
      if (sync_reg[1] == sync_reg[2]) begin
         level_next = sync_reg[2];
      end
      // Edges during our own drive are ignored, so a host pulse overlapping it is lost.
      fall_next = level_reg & ~level_next & ~lm.mask; // R4
      rise_next = ~level_reg & level_next & ~lm.mask;
      cnt_next  = cnt_reg;
      if (fall_next) begin
         cnt_next = '0;
      end else if (~level_reg && lm.tick && cnt_reg != {CNT_W{1'b1}}) begin
         cnt_next = cnt_reg + 1'b1; // R10
      end
   end

   // Registers of the synchroniser and the low-time counter.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_reg  <= {3{DCA_PIN_IDLE}};
         level_reg <= DCA_PIN_IDLE;
         fall_reg  <= 1'b0;
         rise_reg  <= 1'b0;
         cnt_reg   <= '0;
      end else begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
         fall_reg  <= fall_next;
         rise_reg  <= rise_next;
         cnt_reg   <= cnt_next;
      end
   end

   // The count is stable at the rising edge, so the classification is valid with the rise pulse.
   assign lm.fall     = fall_reg;
   assign lm.rise     = rise_reg;
   assign lm.low_cnt  = cnt_reg;
   assign lm.long_low = (cnt_reg >= CNT_W'(LONG_TICKS)); // R2

endmodule : dca_low_meter

// ---- tb/dca_abort_chk.sv ----
`timescale 1ns/1ns
module dca_abort_chk (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Pin and command status.
   input wire logic debug_pin_i,
   input wire logic debug_pin_o,
   input wire logic debug_pin_oe_o,
   input wire logic cmd_pending_i,
   input wire logic cmd_run_to_bp_i,
   // Events.
   input wire logic cmd_abort_o,
   input wire logic ack_cancel_o,
   input wire logic sync_req_o,
   input wire logic cmd_start_o,
   input wire logic ser_tick_o
);
   import dca_pkg::*;
   logic       pin_reg, pin_next, abt_reg, abt_next;
   logic [7:0] low_reg, low_next, len_reg, len_next, age_reg, age_next;
   // Low length in ticks, last finished low length, and cycles since the last fall.
   always_comb begin
      pin_next = debug_pin_i;
      low_next = debug_pin_i ? 8'h00 : low_reg + 8'(ser_tick_o && low_reg != 8'hff);
      len_next = (!pin_reg && debug_pin_i) ? low_reg : len_reg;
      age_next = (pin_reg && !debug_pin_i) ? 8'h00 : age_reg + 8'(age_reg != 8'hff);
      abt_next = (cmd_abort_o && !sync_req_o) || (abt_reg && !cmd_start_o);
   end
   // Reset puts the pin copy at its idle level so release shows no false edge.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         {pin_reg, abt_reg} <= 2'h2;
         {low_reg, len_reg, age_reg} <= {8'h00, 8'h00, 8'hff};
      end else begin
         {pin_reg, abt_reg} <= {pin_next, abt_next};
         {low_reg, len_reg, age_reg} <= {low_next, len_next, age_next};
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_resp; ##[0:2] debug_pin_oe_o; endsequence
   sequence s_quiet; !debug_pin_oe_o [*8]; endsequence
   property p_bp_keep; cmd_pending_i && cmd_run_to_bp_i |-> !cmd_abort_o; endproperty
   a_bp_keep: assert property (p_bp_keep) else $error("breakpoint run aborted");
   property p_pin_low; debug_pin_oe_o |-> !debug_pin_o; endproperty
   a_pin_low: assert property (p_pin_low) else $error("debug pin driven high");
   // The sync filter may shift the measured length by up to two ticks, hence the margin.
   property p_sync_len; sync_req_o |-> len_reg >= 8'h7e; endproperty
   a_sync_len: assert property (p_sync_len) else $error("short low taken as sync");
   property p_short_quiet; cmd_abort_o && !sync_req_o |=> s_quiet; endproperty
   a_short_quiet: assert property (p_short_quiet) else $error("response after short abort");
   property p_sync_resp; sync_req_o |-> s_resp; endproperty
   a_sync_resp: assert property (p_sync_resp) else $error("no timing response");
   property p_cancel_edge; ack_cancel_o |-> age_reg inside {[8'h02:8'h08]}; endproperty
   a_cancel_edge: assert property (p_cancel_edge) else $error("cancel not at fall");
   property p_start; cmd_start_o |-> abt_reg && age_reg inside {[8'h02:8'h08]}; endproperty
   a_start: assert property (p_start) else $error("start without abort and fall");
   property p_sync_abort; sync_req_o && cmd_pending_i && !cmd_run_to_bp_i |-> cmd_abort_o; endproperty
   a_sync_abort: assert property (p_sync_abort) else $error("sync left command pending");
   property p_long; !pin_reg && debug_pin_i && low_reg >= 8'h82 && !debug_pin_oe_o |-> ##[3:7] sync_req_o;
   endproperty
   a_long: assert property (p_long) else $error("long low not classified");
endmodule : dca_abort_chk

bind dca_abort_top dca_abort_chk u_chk (.sys_clk_i, .rst_i, .debug_pin_i, .debug_pin_o, .debug_pin_oe_o, .cmd_pending_i,
   .cmd_run_to_bp_i, .cmd_abort_o, .ack_cancel_o, .sync_req_o, .cmd_start_o, .ser_tick_o);

// ---- tb/dca_host_model.sv ----
`timescale 1ns/1ns
module dca_host_model #(
   parameter int unsigned DIV = 1
) (
   // Clock and device drive.
   input  wire logic sys_clk_i,
   input  wire logic dev_oe_i,
   // Resolved pin level.
   output logic      pin_o
);
   logic low_reg = 1'b0;
   // Open drain with a pull-up: a released pin reads high.
   assign pin_o = ~(low_reg | dev_oe_i);
   // Lengths are whole ticks; ones shorter than four ticks are stretched to four.
   task automatic low_pulse(input int n);
      int i;
      // Wait up to 500 cycles for the device to stop answering before pulling, so no pulse is lost.
      for (i = 0; i < 500; i++) begin
         @(negedge sys_clk_i);
         if (dev_oe_i === 1'b0) break;
      end
      // Leave the pull-up visible for a few cycles so the device filter sees our edge.
      repeat (4) @(posedge sys_clk_i);
      low_reg <= 1'b1;
      repeat (((n < 4) ? 4 : n) * DIV) @(posedge sys_clk_i);
      low_reg <= 1'b0;
   endtask : low_pulse
endmodule : dca_host_model

// ---- tb/tb_debug_command_abort.sv ----
`timescale 1ns/1ns
module tb_debug_command_abort;
   import dca_pkg::*;
   localparam int unsigned DIV  = 1;
   localparam int unsigned ACKT = 2;
   localparam int unsigned RESP = 16;
   logic            sys_clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            pend = 1'b0;
   logic            bp = 1'b0;
   logic            done = 1'b0;
   logic            clr = 1'b1;
   logic            rs = 1'b0;
   logic            pin;
   logic [5:0]      ev;
   logic [5:0][7:0] cnt;
   int              n_errors = 0;
   int              checks = 0;
   logic            ack_off = 1'b0;
   string           nm [6] = '{"abort", "cancel", "sync", "bit fall", "start", "resp length"};

   dca_abort_top #(.SER_DIV(DIV), .ACK_TICKS(ACKT), .SYNC_RESP_TICKS(RESP)) DUT (
      .sys_clk_i, .rst_i, .debug_pin_i(pin), .debug_pin_o(), .debug_pin_oe_o(ev[5]), .cmd_pending_i(pend),
      .cmd_run_to_bp_i(bp), .cmd_done_i(done), .cmd_abort_o(ev[0]), .ack_cancel_o(ev[1]),
      .sync_req_o(ev[2]), .cmd_bit_fall_o(ev[3]), .cmd_start_o(ev[4]), .ser_tick_o());
   dca_host_model #(.DIV(DIV)) u_host (.sys_clk_i, .dev_oe_i(ev[5]), .pin_o(pin));

   // Clock at 100 MHz.
   initial forever #5 sys_clk_i = ~sys_clk_i;
   // Tally each event and the cycles the device holds the pin low.
   always @(posedge sys_clk_i)
      for (int k = 0; k < 6; k++) cnt[k] <= clr ? 8'h00 : cnt[k] + 8'(ev[k]);

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // Bits: response, start, bit fall, sync, cancel, abort; a resync only yields a start.
   function automatic logic [5:0] expect_ev(int n, logic p, logic b, logic r);
      logic lng;
      lng = (n >= DCA_SYNC_MIN_TICKS);
      if (r) return 6'h10;
      if (!p) return {lng, 2'h1, lng, 2'h0};
      return {lng, 2'h0, lng, 1'b1, !b};
   endfunction : expect_ev

   // Bounded wait until the device lets go of the pin.
   task automatic wait_idle();
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge sys_clk_i);
         if (ev[5] === 1'b0) break;
      end
      if (i == 400) begin
         chk("pin release", 8'h00, 8'h01);
         report_and_stop();
      end
      @(posedge sys_clk_i);
   endtask : wait_idle

   task automatic step(input int n, input logic p, input logic b);
      logic [5:0] e;
      e = expect_ev(n, p, b, rs);
      // A breakpoint run whose acknowledge is already cancelled has none left to cancel.
      if (ack_off) e[1] = 1'b0;
      clr <= 1'b1;
      pend <= p;
      bp <= b;
      @(posedge sys_clk_i);
      clr <= 1'b0;
      u_host.low_pulse(n);
      repeat (12) @(posedge sys_clk_i);
      wait_idle();
      for (int k = 0; k < 6; k++) chk(nm[k], (k == 5 && e[5]) ? 8'(RESP) : 8'(e[k]), cnt[k]);
      rs = p && !b && !e[2];
      ack_off = p && b;
      if (p && !b) pend <= 1'b0;
      $display("step low %0d pending %0b bp %0b done", n, p, b);
   endtask : step

   // A plain command acknowledges; a cancelled breakpoint run stays silent.
   task automatic finish_cmd(input logic [7:0] exp);
      ack_off = 1'b0;
      clr <= 1'b1;
      pend <= 1'b1;
      @(posedge sys_clk_i);
      clr <= 1'b0;
      done <= 1'b1;
      @(posedge sys_clk_i);
      done <= 1'b0;
      pend <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      chk("ack length", exp, cnt[5]);
      $display("finish done");
   endtask : finish_cmd

   initial begin
      int n;
      void'($urandom(83));
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      finish_cmd(8'(ACKT));
      step(20, 1'b1, 1'b0);
      step(6, 1'b0, 1'b0);
      step(4, 1'b0, 1'b0);
      step(140, 1'b0, 1'b0);
      step(127, 1'b1, 1'b0);
      step(5, 1'b0, 1'b0);
      step(128, 1'b1, 1'b0);
      step(8, 1'b0, 1'b0);
      step(30, 1'b1, 1'b1);
      step(130, 1'b1, 1'b1);
      finish_cmd(8'h00);
      repeat (8) begin
         n = ($urandom % 2) ? $urandom_range(160, 128) : $urandom_range(127, 4);
         step(n, 1'b1, 1'b0);
         step(8, 1'b0, 1'b0);
      end
      report_and_stop();
   end
endmodule : tb_debug_command_abort
